// *** bench/adc_seq0_sample_control_tb_top.sv ***
// Purpose: self-checking bench of the sequencer-0 sample control block
// Assumes: one-cycle Wishbone answer, result pushed the cycle after done
// Notes:   stimulus from a fixed-seed xorshift, corner cases first
`timescale 1ns/1ps
module adc_seq0_sample_control_tb_top;
   import asc_pkg::*;
   logic        clk  = 1'b0;
   logic        rst  = 1'b1;
   logic        cyc  = 1'b0;
   logic        we   = 1'b0;
   logic [7:0]  adr  = 8'h00;
   logic [3:0]  sel  = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic        ack;
   logic        trig = 1'b0;
   logic        start;
   logic [2:0]  chan;
   logic        done = 1'b0;
   logic [9:0]  cdat = 10'h0;
   logic        rwr;
   logic [9:0]  rdata;
   logic [2:0]  rslot;
   logic        raw;
   logic        busy;
   logic        irq;
   logic [31:0] seed = 32'hb2be;
   logic [31:0] v;
   int          errors = 0;
   int          checks_done = 0;

   asc_seq0_ctrl i_dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
      .WB_ACK_OUT(ack), .TRIG_IN(trig), .CONV_START_OUT(start), .CONV_CHAN_OUT(chan),
      .CONV_DONE_IN(done), .CONV_DATA_IN(cdat), .RESULT_WR_OUT(rwr), .RESULT_DATA_OUT(rdata),
      .RESULT_SLOT_OUT(rslot), .RAW_IRQ_OUT(raw), .BUSY_OUT(busy), .IRQ_OUT(irq));

   always #20 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // lowest slot carrying an end bit, the eighth when none does
   function automatic int last_slot(logic [31:0] c);
      for (int n = ASC_SLOTS - 1; n >= 0; n--)
         if (c[ASC_STRIDE*n+ASC_END_POS])
            last_slot = n;
      if (c[29:0] & 30'h2222_2222 ^ 30'h0) return last_slot;
      return ASC_SLOTS - 1;
   endfunction

   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // request held until ack is seen at a rising edge, released right after it
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int t;
      @(posedge clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      for (t = 0; t < 20; t++)
      begin
         @(posedge clk);
         if (ack === 1'b1)
            break;
      end
      rd = rdat;
      // released bus shows the inverse so a late sample would be caught
      cyc  <= 1'b0;
      we   <= ~w;
      adr  <= ~a;
      wdat <= ~d;
      if (t >= 20)
         chk(0, 1, "no ack");
   endtask

   task automatic trigger();
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
   endtask

   // shots 0: whole sequence from one trigger, else one sample per trigger
   task automatic run(logic [31:0] c, logic [31:0] m, int shots);
      int k;
      int s;
      int cnt;
      logic ie;
      logic [9:0] d;
      k = last_slot(c);
      cnt = (shots == 0) ? k + 1 : shots;
      ie = 1'b0;
      wb(1, ASC_OFF_MUX, m);
      wb(1, ASC_OFF_CTL, c);
      wb(1, ASC_OFF_STAT, 32'h3);
      for (int i = 0; i < cnt; i++)
      begin
         s = i % (k + 1);
         if (i == 0 || shots != 0)
            trigger();
         for (int t = 0; t < 40 && start !== 1'b1; t++)
            @(posedge clk);
         chk(start, 1, "start");
         chk(chan, m[4*s+:3], "channel");
         repeat (rnd() % 4) @(posedge clk);
         d = 10'(rnd());
         done <= 1'b1;
         cdat <= d;
         @(posedge clk);
         done <= 1'b0;
         cdat <= ~d;
         @(posedge clk);
         chk(rwr, 1, "result push");
         chk(rslot, s, "result slot");
         chk(rdata, d, "result data");
         chk(raw, c[4*s+2], "raw irq");
         chk(busy, shots == 0 && i < k, "busy at end");
         ie = ie | c[4*s+2];
      end
      wb(0, ASC_OFF_STAT, 0);
      chk(rd[1:0], {1'b1, ie}, "status");
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wb(0, ASC_OFF_CTL, 0);
      chk(rd, ASC_CTL_RESET, "ctl reset");
      wb(0, ASC_OFF_MASK, 0);
      chk(rd, 0, "mask reset");
      wb(1, 8'h40, 32'hffff_ffff);
      wb(0, 8'h40, 0);
      chk(rd, 0, "unmapped");
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : rnd();
         wb(1, ASC_OFF_CTL, v);
         wb(0, ASC_OFF_CTL, 0);
         chk(rd, v & ASC_CTL_WMASK, "ctl rw");
      end
      // default layout: eight slots, no raw interrupt
      run(ASC_CTL_RESET, rnd() & ASC_MUX_WMASK, 0);
      chk(irq, 0, "irq masked");
      wb(1, ASC_OFF_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 0, "irq other bit masked");
      wb(1, ASC_OFF_MASK, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 1, "irq raised");
      wb(1, ASC_OFF_STAT, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 0, "irq cleared");
      // a lone end bit on slot 0, then several end bits: the lowest wins
      // the random setups may leave every end bit clear, the eighth slot then ends the sequence
      run(32'h0000_0006, rnd() & ASC_MUX_WMASK, 0);
      run(32'h2220_0444, rnd() & ASC_MUX_WMASK, 0);
      for (int i = 0; i < 5; i++)
         run(rnd() & ASC_CTL_WMASK & ~32'h1, rnd() & ASC_MUX_WMASK, 0);
      // reset in mid-sequence
      trigger();
      repeat (3) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk(busy, 0, "busy in reset");
      chk(start, 0, "start in reset");
      rst <= 1'b0;
      wb(0, ASC_OFF_CTL, 0);
      chk(rd, ASC_CTL_RESET, "ctl after reset");
      run(32'h0000_0241, rnd() & ASC_MUX_WMASK, 5);
      print_verdict();
   end

   initial
   begin
      #(40 * 20000);
      errors++;
      print_verdict();
   end
endmodule

// *** rtl/asc_first_set.sv ***
// Purpose: lowest set bit finder for the end-of-sequence markers
// Assumes: WIDTH is a power of two matching 2**IDX_W
// Notes:   with no bit set the top index is returned
`timescale 1ns/1ps
module asc_first_set
#(
   parameter int WIDTH = 8,
   parameter int IDX_W = 3
)
(
   input  wire logic [WIDTH-1:0] bits_in,
   output logic      [IDX_W-1:0] index_out
);
   always_comb
   begin
      index_out = IDX_W'(WIDTH - 1);
      for (int i = WIDTH - 1; i >= 0; i--)
      begin
         if (bits_in[i])
         begin
            index_out = IDX_W'(i);
         end
      end
   end
endmodule

// *** rtl/asc_pkg.sv ***
// Purpose: constants and types of the sequencer-0 sample control block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   register offsets and status layout are local choices
// Function
// [RL1] software must set the end-of-sequence bit of at least one slot, any slot may carry it
// [RL2] the control register is 32 bits wide and holds the setup of eight sample slots
// [RL3] slot n interrupt enable sits at bit 4n+2 and lets that slot's completion raise the raw interrupt
// [RL4] slot n end-of-sequence bit sits at bit 4n+1 and marks that slot as the last sample
// [RL5] after reset only the eighth slot's end bit reads one, every other end and enable bit reads zero
// [RL6] bit 0 selects one-shot mode, resets to zero, and makes each trigger take a single sample
// [RL7] reserved bits read zero and ignore writes, and software leaves them alone
// [RL8] each slot converts the analog input named by its 3-bit select field, slot 0 in the lowest field
// [RL9] results leave in slot order starting at slot 0
// [RL10] stepping runs upward from slot 0 and stops at the lowest slot whose end bit is set
package asc_pkg;
   localparam int          ASC_ADR_W      = 8;
   localparam int          ASC_DATA_W     = 10;
   localparam int          ASC_SLOTS      = 8;
   localparam int          ASC_SLOT_W     = 3;
   localparam int          ASC_MUX_W      = 3;
   localparam int          ASC_STRIDE     = 4;
   localparam int          ASC_ONESHOT    = 0;
   localparam int          ASC_END_POS    = 1;
   localparam int          ASC_IE_POS     = 2;
   localparam logic [7:0]  ASC_OFF_CTL    = 8'h00;
   localparam logic [7:0]  ASC_OFF_MUX    = 8'h04;
   localparam logic [7:0]  ASC_OFF_STAT   = 8'h08;
   localparam logic [7:0]  ASC_OFF_MASK   = 8'h0c;
   localparam logic [31:0] ASC_CTL_RESET  = 32'h2000_0000;
   localparam logic [31:0] ASC_CTL_WMASK  = 32'h6666_6667;
   localparam logic [31:0] ASC_MUX_WMASK  = 32'h7777_7777;
   localparam logic [31:0] ASC_MUX_RESET  = 32'h0000_0000;
   // status and mask: bit 0 sample interrupt, bit 1 sequence done
   localparam int          ASC_EV_W       = 2;
   localparam int          ASC_EV_SAMPLE  = 0;
   localparam int          ASC_EV_SEQ     = 1;
   localparam logic [1:0]  ASC_EV_RESET   = 2'h0;
   // read-only view in the status word
   localparam int          ASC_ST_SLOT_LO = 4;
   localparam int          ASC_ST_BUSY    = 8;
   localparam logic [2:0]  ASC_SLOT_FIRST = 3'h0;
   localparam logic [2:0]  ASC_SLOT_STEP  = 3'h1;

   typedef enum logic [1:0]
   {
      ASC_IDLE  = 2'b00,
      ASC_START = 2'b01,
      ASC_WAIT  = 2'b10
   } asc_state_t;
endpackage

// *** rtl/asc_seq0_ctrl.sv ***
// Purpose: sequencer-0 sample control registers and slot stepping
// Assumes: trigger and converter handshake come from logic on CLK_SYS_IN
// Notes:   a missing end bit behaves as if the eighth slot carried it
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module asc_seq0_ctrl
(
   input  wire logic                            CLK_SYS_IN,
   input  wire logic                            RESET_IN,
   input  wire logic                            WB_CYC_IN,
   input  wire logic                            WB_STB_IN,
   input  wire logic                            WB_WE_IN,
   input  wire logic [asc_pkg::ASC_ADR_W-1:0]   WB_ADR_IN,
   input  wire logic [3:0]                      WB_SEL_IN,
   input  wire logic [31:0]                     WB_DAT_IN,
   output logic      [31:0]                     WB_DAT_OUT,
   output logic                                 WB_ACK_OUT,
   input  wire logic                            TRIG_IN,
   output logic                                 CONV_START_OUT,
   output logic      [asc_pkg::ASC_MUX_W-1:0]   CONV_CHAN_OUT,
   input  wire logic                            CONV_DONE_IN,
   input  wire logic [asc_pkg::ASC_DATA_W-1:0]  CONV_DATA_IN,
   output logic                                 RESULT_WR_OUT,
   output logic      [asc_pkg::ASC_DATA_W-1:0]  RESULT_DATA_OUT,
   output logic      [asc_pkg::ASC_SLOT_W-1:0]  RESULT_SLOT_OUT,
   output logic                                 RAW_IRQ_OUT,
   output logic                                 BUSY_OUT,
   output logic                                 IRQ_OUT
);
   import asc_pkg::*;

   logic        [31:0]           ctl_ff;
   logic        [31:0]           mux_ff;
   logic        [ASC_EV_W-1:0]   status_ff;
   logic        [ASC_EV_W-1:0]   mask_ff;
   logic                         ack_ff;
   logic        [31:0]           rdat_ff;
   asc_state_t                   state_ff;
   asc_state_t                   nxt_state;
   logic        [ASC_SLOT_W-1:0] slot_ff;
   logic        [ASC_SLOT_W-1:0] nxt_slot;
   logic        [ASC_SLOT_W-1:0] shot_ff;
   logic        [ASC_SLOT_W-1:0] nxt_shot;
   logic        [ASC_MUX_W-1:0]  chan_ff;
   logic                         wr_ff;
   logic        [ASC_DATA_W-1:0] rdata_ff;
   logic        [ASC_SLOT_W-1:0] rslot_ff;
   logic                         raw_ff;

   wire         [ASC_SLOTS-1:0]  end_bits;
   wire         [ASC_SLOTS-1:0]  ie_bits;
   wire         [ASC_MUX_W-1:0]  mux_sel [ASC_SLOTS];
   wire         [ASC_SLOT_W-1:0] end_slot;
   wire                          one_shot = ctl_ff[ASC_ONESHOT];

   // [RL3] [RL4] [RL8] per-slot fields
   for (genvar i = 0; i < ASC_SLOTS; i++)
   begin : g_slot
      assign end_bits[i] = ctl_ff[ASC_STRIDE*i + ASC_END_POS];
      assign ie_bits[i]  = ctl_ff[ASC_STRIDE*i + ASC_IE_POS];
      assign mux_sel[i]  = mux_ff[ASC_STRIDE*i +: ASC_MUX_W];
   end

   // [RL10] lowest marked slot ends the sequence
   asc_first_set #(.WIDTH(ASC_SLOTS), .IDX_W(ASC_SLOT_W)) u_end
   (
      .bits_in   (end_bits),
      .index_out (end_slot)
   );

   // bus decode
   wire        req      = WB_CYC_IN & WB_STB_IN;
   wire        wb_wr    = req & WB_WE_IN & ack_ff;
   wire [31:0] lane     = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
   wire        hit_ctl  = WB_ADR_IN == ASC_OFF_CTL;
   wire        hit_mux  = WB_ADR_IN == ASC_OFF_MUX;
   wire        hit_stat = WB_ADR_IN == ASC_OFF_STAT;
   wire        hit_mask = WB_ADR_IN == ASC_OFF_MASK;
   wire        wr_ctl   = wb_wr & hit_ctl;
   wire        wr_mux   = wb_wr & hit_mux;
   wire        wr_stat  = wb_wr & hit_stat & WB_SEL_IN[0];
   wire        wr_mask  = wb_wr & hit_mask & WB_SEL_IN[0];
   // [RL2] [RL7] byte-lane merge, reserved bits kept at zero
   wire [31:0] nxt_ctl  = ((ctl_ff & ~lane) | (WB_DAT_IN & lane)) & ASC_CTL_WMASK;
   wire [31:0] nxt_mux  = ((mux_ff & ~lane) | (WB_DAT_IN & lane)) & ASC_MUX_WMASK;

   wire [31:0] stat_word = {23'h000000, BUSY_OUT, 1'b0, slot_ff, 2'h0, status_ff};
   wire [31:0] rd_mux    = hit_ctl  ? ctl_ff :
                           hit_mux  ? mux_ff :
                           hit_stat ? stat_word :
                           hit_mask ? {30'h00000000, mask_ff} : 32'h0000_0000;

   // sequencer
   wire                  cur_ie   = ie_bits[slot_ff];
   wire [ASC_MUX_W-1:0]  cur_mux  = mux_sel[slot_ff];
   wire                  done     = (state_ff == ASC_WAIT) & CONV_DONE_IN;
   wire                  at_end   = slot_ff == end_slot;
   // [RL6] one sample per trigger in one-shot mode
   wire                  cur_last = one_shot | at_end;
   // pointer may sit past a newly shortened sequence, so wrap it
   wire [ASC_SLOT_W-1:0] shot_start = (shot_ff > end_slot) ? ASC_SLOT_FIRST : shot_ff;
   wire [ASC_SLOT_W-1:0] slot_inc   = slot_ff + ASC_SLOT_STEP;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_slot  = slot_ff;
      nxt_shot  = shot_ff;
      unique case (state_ff)
         ASC_IDLE:
         begin
            if (TRIG_IN)
            begin
               nxt_state = ASC_START;
               // [RL9] full sequence always opens at slot 0
               nxt_slot  = one_shot ? shot_start : ASC_SLOT_FIRST;
            end
         end
         ASC_START:
         begin
            nxt_state = ASC_WAIT;
         end
         ASC_WAIT:
         begin
            if (CONV_DONE_IN)
            begin
               if (cur_last)
               begin
                  nxt_state = ASC_IDLE;
                  nxt_shot  = at_end ? ASC_SLOT_FIRST : slot_inc;
               end
               else
               begin
                  // [RL10] step upward
                  nxt_state = ASC_START;
                  nxt_slot  = slot_inc;
               end
            end
         end
         default:
         begin
            nxt_state = ASC_IDLE;
         end
      endcase
   end

   // [RL3] unmasked per-slot completion event
   wire [ASC_EV_W-1:0] ev_set = {done & cur_last, done & cur_ie};
   wire [ASC_EV_W-1:0] ev_clr = wr_stat ? WB_DAT_IN[ASC_EV_W-1:0] : ASC_EV_RESET;

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff  <= req & ~ack_ff;
         rdat_ff <= (req & ~ack_ff) ? rd_mux : rdat_ff;
      end
   end

   // [RL5] reset leaves only the eighth end marker set
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         ctl_ff  <= ASC_CTL_RESET;
         mux_ff  <= ASC_MUX_RESET;
         mask_ff <= ASC_EV_RESET;
      end
      else
      begin
         ctl_ff  <= wr_ctl  ? nxt_ctl : ctl_ff;
         mux_ff  <= wr_mux  ? nxt_mux : mux_ff;
         mask_ff <= wr_mask ? WB_DAT_IN[ASC_EV_W-1:0] : mask_ff;
      end
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         status_ff <= ASC_EV_RESET;
      end
      else
      begin
         status_ff <= (status_ff & ~ev_clr) | ev_set;
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         state_ff <= ASC_IDLE;
         slot_ff  <= ASC_SLOT_FIRST;
         shot_ff  <= ASC_SLOT_FIRST;
         chan_ff  <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         slot_ff  <= nxt_slot;
         shot_ff  <= nxt_shot;
         // [RL8] input select of the slot about to convert
         chan_ff  <= mux_sel[nxt_slot];
      end
   end

   // [RL9] results leave tagged with their slot, in stepping order
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         wr_ff    <= 1'b0;
         rdata_ff <= '0;
         rslot_ff <= ASC_SLOT_FIRST;
         raw_ff   <= 1'b0;
      end
      else
      begin
         wr_ff    <= done;
         rdata_ff <= done ? CONV_DATA_IN : rdata_ff;
         rslot_ff <= done ? slot_ff : rslot_ff;
         raw_ff   <= done & cur_ie;
      end
   end

   assign WB_ACK_OUT      = ack_ff;
   assign WB_DAT_OUT      = rdat_ff;
   assign CONV_START_OUT  = state_ff == ASC_START;
   assign CONV_CHAN_OUT   = chan_ff;
   assign RESULT_WR_OUT   = wr_ff;
   assign RESULT_DATA_OUT = rdata_ff;
   assign RESULT_SLOT_OUT = rslot_ff;
   assign RAW_IRQ_OUT     = raw_ff;
   assign BUSY_OUT        = state_ff != ASC_IDLE;
   assign IRQ_OUT         = |(status_ff & mask_ff);

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN);

   sequence seq_sample_done;
      state_ff == ASC_WAIT && CONV_DONE_IN;
   endsequence

   sequence seq_full_trigger;
      state_ff == ASC_IDLE && TRIG_IN && !one_shot;
   endsequence

   a_ack_single_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack held longer than one cycle");
   a_ctl_reset_image: assert property ($fell(RESET_IN) |-> ctl_ff == ASC_CTL_RESET) // [RL5]
      else $error("control register reset value wrong");
   a_reserved_read_zero: assert property ((ctl_ff & ~ASC_CTL_WMASK) == 32'h0000_0000) // [RL7]
      else $error("reserved control bit set");
   a_ctl_full_write: assert property ((wr_ctl && WB_SEL_IN == 4'hf) |=> // [RL2]
      ctl_ff == ($past(WB_DAT_IN) & ASC_CTL_WMASK))
      else $error("control write not stored");
   a_slot_irq_enable: assert property (seq_sample_done |=> RAW_IRQ_OUT == $past(cur_ie) && RESULT_WR_OUT) // [RL3]
      else $error("raw interrupt does not follow slot enable");
   a_end_stops_seq: assert property (seq_sample_done ##0 at_end |=> state_ff == ASC_IDLE) // [RL4]
      else $error("sequence ran past its end slot");
   a_step_upward: assert property (seq_sample_done ##0 !cur_last |=> // [RL10]
      state_ff == ASC_START && slot_ff == $past(slot_inc))
      else $error("slot did not step upward");
   a_oneshot_single: assert property (seq_sample_done ##0 one_shot |=> state_ff == ASC_IDLE) // [RL6]
      else $error("one-shot took more than one sample");
   // done may arrive right after the start pulse, so only one waiting cycle is certain
   a_full_from_zero: assert property (seq_full_trigger |=> // [RL9]
      slot_ff == ASC_SLOT_FIRST ##1 state_ff == ASC_WAIT)
      else $error("full sequence not started at slot 0");
   a_chan_from_select: assert property (state_ff == ASC_START |-> CONV_CHAN_OUT == cur_mux) // [RL8]
      else $error("converter channel not from slot select");
endmodule
